/* File: hw/pat_pkg.sv */
// pat_pkg: register indices, field positions, reset values and carrier types of the auto-reload PWM timer.
// assumes an APB slave with 32-bit data, one register per aligned word, byte address = 4 * index.
package pat_pkg;

   localparam int PAT_PADDR_W = 12;
   localparam int PAT_PWM_CH = 4;
   localparam int PAT_CAP_CH = 2;

   // register indices; byte address is four times the index
   localparam logic [9:0] PAT_IDX_DUTY3 = 10'h073;
   localparam logic [9:0] PAT_IDX_DUTY0 = 10'h076;
   localparam logic [9:0] PAT_IDX_PWM_OUTPUT_CONTROL = 10'h077;
   localparam logic [9:0] PAT_IDX_CSR = 10'h078;
   localparam logic [9:0] PAT_IDX_CAR = 10'h079;
   localparam logic [9:0] PAT_IDX_ARR = 10'h07A;
   localparam logic [9:0] PAT_IDX_CAPCSR = 10'h07B;
   localparam logic [9:0] PAT_IDX_CAPDATA1 = 10'h07C;

   // timer_control_status fields
   localparam int PAT_CSR_CLKSEL = 7;
   localparam int PAT_CSR_DIV_LSB = 4;
   localparam int PAT_CSR_RUN = 3;
   localparam int PAT_CSR_FORCE_RELOAD = 2;
   localparam int PAT_CSR_OIE = 1;
   localparam int PAT_CSR_OVF = 0;

   // pwm_output_control fields
   localparam int PAT_PWM_OUTPUT_CONTROL_OE_LSB = 4;
   localparam int PAT_PWM_OUTPUT_CONTROL_POL_LSB = 0;

   // capture_control_status fields
   localparam int PAT_CAP_SEL_LSB = 4;
   localparam int PAT_CAP_IE_LSB = 2;
   localparam int PAT_CAP_FLAG_LSB = 0;

   localparam logic [7:0] PAT_RESET_BYTE = 8'h00;
   localparam logic [7:0] PAT_COUNT_TOP = 8'hFF;
   localparam logic [6:0] PAT_PRESC_RESET = 7'h00;

   typedef struct packed {
      logic clkSel;
      logic [2:0] divSel;
      logic run;
      logic ovfIe;
   } pat_ctrl_t;

   localparam pat_ctrl_t PAT_CTRL_RESET = '{clkSel: 1'b0, divSel: 3'h0, run: 1'b0, ovfIe: 1'b0};

endpackage

/* File: hw/pat_timer.sv */
// pat_timer: 8-bit auto-reload timer, 7-bit prescaler, four PWM outputs, two edge capture/interrupt inputs.
// assumes an APB master on ref_clk; pins, halt state and external clock are plain inputs on ref_clk.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns

// Behaviour
// - capture pin edge raises external interrupt request
// - per-channel edge select and interrupt enable
// - enabled capture edge wakes core from halt
// - bit 7 selects cpu or external clock
// - bits 6:4 divide by two to power
// - run bit clear freezes prescaler and counter
// - force-reload bit always reads zero
// - force reload loads reload value, clears prescaler
// - overflow interrupt only when enable set
// - overflow flag set on FFh wrap
// - status read clears overflow flag; no software set
// - counter access reads live, writes immediately
// - overflow reloads counter from reload register
// - outputs take start level at reload
// - output enable bits connect each channel
// - high at or below compare, polarity inverts
// - polarity change inverts output at once
// - duty register sets second pulse edge
// - all registers reset to zero
// - compare copied from duty at overflow only
// - counter increments once per prescaler tick
// - capture sets flag; data read clears it
// - period is 256 minus reload value
module pat_timer
   import pat_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PAT_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extClk,
   input wire logic [PAT_CAP_CH-1:0] captureInputPin,
   input wire logic halted,
   output logic [PAT_PWM_CH-1:0] pwmOut,
   output logic [PAT_PWM_CH-1:0] pwmOe,
   output logic overflowIrq,
   output logic captureIrq,
   output logic wakeReq
);

   pat_ctrl_t ctrl;
   logic overflowFlag;
   logic [7:0] counter;
   logic [6:0] presc;
   logic [7:0] reloadValue;
   logic [PAT_PWM_CH-1:0] pwmPolarity;
   logic [PAT_PWM_CH-1:0] outEnable;
   logic [7:0] duty [PAT_PWM_CH];
   logic [7:0] compareValue [PAT_PWM_CH];
   logic [PAT_CAP_CH-1:0] captureEdgeSelect;
   logic [PAT_CAP_CH-1:0] captureIrqEnable;
   logic [PAT_CAP_CH-1:0] captureFlag;
   logic [PAT_CAP_CH-1:0] flagSeen;
   logic [7:0] captureData [PAT_CAP_CH];

   // synchronisers: stage 1 feeds stage 2 only, edges are taken from stage 2 and its delayed copy
   logic extMeta, extSync, extPrev;
   logic [PAT_CAP_CH-1:0] capMeta, capSync, capPrev;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         extMeta <= 1'b0;
         extSync <= 1'b0;
         extPrev <= 1'b0;
         capMeta <= '0;
         capSync <= '0;
         capPrev <= '0;
      end else begin
         extMeta <= extClk;
         extSync <= extMeta;
         extPrev <= extSync;
         capMeta <= captureInputPin;
         capSync <= capMeta;
         capPrev <= capSync;
      end
   end

   wire extRise = extSync & ~extPrev;
   wire [PAT_CAP_CH-1:0] capRise = capSync & ~capPrev;
   wire [PAT_CAP_CH-1:0] capFall = ~capSync & capPrev;
   wire [PAT_CAP_CH-1:0] capHit = (captureEdgeSelect & capRise) | (~captureEdgeSelect & capFall);

   // bus decode
   wire setupPhase = psel & ~penable;
   wire accessDone = psel & penable & pready;
   wire busWrite = accessDone & pwrite;
   wire busRead = accessDone & ~pwrite;
   wire [9:0] wordIdx = paddr[PAT_PADDR_W-1:2];
   wire aligned = (paddr[1:0] == 2'b00);
   wire hitPwmcr = aligned & (wordIdx == PAT_IDX_PWM_OUTPUT_CONTROL);
   wire hitCsr = aligned & (wordIdx == PAT_IDX_CSR);
   wire hitCar = aligned & (wordIdx == PAT_IDX_CAR);
   wire hitArr = aligned & (wordIdx == PAT_IDX_ARR);
   wire hitCapCsr = aligned & (wordIdx == PAT_IDX_CAPCSR);
   wire hitDutyAny = aligned & (wordIdx >= PAT_IDX_DUTY3) & (wordIdx <= PAT_IDX_DUTY0);
   wire hitCapData = aligned & (wordIdx >= PAT_IDX_CAPDATA1) & (wordIdx <= PAT_IDX_CAPDATA1 + 10'h001);
   wire mapped = hitDutyAny | hitPwmcr | hitCsr | hitCar | hitArr | hitCapCsr | hitCapData;
   wire [1:0] dutySlot = 2'(PAT_IDX_DUTY0 - wordIdx);
   wire capSlot = wordIdx[0] ^ PAT_IDX_CAPDATA1[0];

   wire wrCsr = busWrite & hitCsr;
   wire wrCar = busWrite & hitCar;
   wire forceLoad = wrCsr & pwdata[PAT_CSR_FORCE_RELOAD];
   wire wrPwmcr = busWrite & hitPwmcr;

   // prescaler and counter
   wire inputTick = ctrl.clkSel ? extRise : 1'b1;
   wire [6:0] divMask = 7'((8'h01 << ctrl.divSel) - 8'h01);
   wire prescStep = ctrl.run & inputTick;
   wire counterTick = prescStep & ((presc & divMask) == divMask);
   // a software load in the same cycle wins over the wrap
   wire wrap = counterTick & (counter == PAT_COUNT_TOP) & ~wrCar & ~forceLoad;

   logic [7:0] next_counter;
   logic [6:0] next_presc;
   always_comb begin
      if (wrCar) begin
         next_counter = pwdata[7:0];
      end else if (forceLoad) begin
         next_counter = reloadValue;
      end else if (wrap) begin
         next_counter = reloadValue;
      end else if (counterTick) begin
         next_counter = counter + 8'h01;
      end else begin
         next_counter = counter;
      end
      if (wrCar | forceLoad) begin
         next_presc = PAT_PRESC_RESET;
      end else if (prescStep) begin
         next_presc = presc + 7'h01;
      end else begin
         next_presc = presc;
      end
   end

   // flag clears only when the snapshot sent to software had it set, so no event is lost
   wire next_ovf = wrap | (overflowFlag & ~(busRead & hitCsr & prdata[PAT_CSR_OVF]));
   wire next_ovfIe = wrCsr ? pwdata[PAT_CSR_OIE] : ctrl.ovfIe;
   wire [PAT_PWM_CH-1:0] next_pol = wrPwmcr ? pwdata[PAT_PWM_OUTPUT_CONTROL_POL_LSB +: PAT_PWM_CH] : pwmPolarity;
   wire [PAT_PWM_CH-1:0] next_oe = wrPwmcr ? pwdata[PAT_PWM_OUTPUT_CONTROL_OE_LSB +: PAT_PWM_CH] : outEnable;
   wire wrArr = busWrite & hitArr;
   wire wrCapCsr = busWrite & hitCapCsr;

   // counter and prescaler; every load is already resolved in next_counter and next_presc
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         counter <= PAT_RESET_BYTE;
         presc <= PAT_PRESC_RESET;
      end else begin
         counter <= next_counter;
         presc <= next_presc;
      end
   end

   // the request uses next-state values so it never lags the flag by a cycle
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         overflowFlag <= 1'b0;
         overflowIrq <= 1'b0;
      end else begin
         overflowFlag <= next_ovf;
         overflowIrq <= next_ovf & next_ovfIe;
      end
   end

   // force-reload is a strobe and is not stored, so it can never be read back as one
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= PAT_CTRL_RESET;
      end else if (wrCsr) begin
         ctrl.clkSel <= pwdata[PAT_CSR_CLKSEL];
         ctrl.divSel <= pwdata[PAT_CSR_DIV_LSB +: 3];
         ctrl.run <= pwdata[PAT_CSR_RUN];
         ctrl.ovfIe <= pwdata[PAT_CSR_OIE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reloadValue <= PAT_RESET_BYTE;
      end else if (wrArr) begin
         reloadValue <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pwmPolarity <= '0;
         outEnable <= '0;
      end else begin
         pwmPolarity <= next_pol;
         outEnable <= next_oe;
      end
   end

   // capture sensitivity and enables; the flags live with their channels below
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         captureEdgeSelect <= '0;
         captureIrqEnable <= '0;
      end else if (wrCapCsr) begin
         captureEdgeSelect <= pwdata[PAT_CAP_SEL_LSB +: PAT_CAP_CH];
         captureIrqEnable <= pwdata[PAT_CAP_IE_LSB +: PAT_CAP_CH];
      end
   end

   // pwm channels
   for (genvar ch = 0; ch < PAT_PWM_CH; ch++) begin : gPwm
      wire wrDuty = busWrite & hitDutyAny & (dutySlot == 2'(ch));
      wire [7:0] next_cmp = wrap ? duty[ch] : compareValue[ch];
      // level follows next-state values so reload, compare and polarity act in their own cycle
      wire level = (next_counter <= next_cmp) ^ next_pol[ch];
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            duty[ch] <= PAT_RESET_BYTE;
            compareValue[ch] <= PAT_RESET_BYTE;
            pwmOut[ch] <= 1'b0;
            pwmOe[ch] <= 1'b0;
         end else begin
            if (wrDuty) begin
               duty[ch] <= pwdata[7:0];
            end
            compareValue[ch] <= next_cmp;
            pwmOut[ch] <= next_oe[ch] & level;
            pwmOe[ch] <= next_oe[ch];
         end
      end
   end

   // capture channels
   logic [PAT_CAP_CH-1:0] next_cf;
   for (genvar ci = 0; ci < PAT_CAP_CH; ci++) begin : gCap
      wire rdData = busRead & hitCapData & (capSlot == 1'(ci)) & flagSeen[ci];
      assign next_cf[ci] = capHit[ci] | (captureFlag[ci] & ~rdData);
      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            captureFlag[ci] <= 1'b0;
            captureData[ci] <= PAT_RESET_BYTE;
         end else begin
            captureFlag[ci] <= next_cf[ci];
            // data frozen while the flag is pending
            if (capHit[ci] & ~captureFlag[ci]) begin
               captureData[ci] <= counter;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         captureIrq <= 1'b0;
         wakeReq <= 1'b0;
      end else begin
         captureIrq <= |(next_cf & captureIrqEnable);
         wakeReq <= halted & |(capHit & captureIrqEnable);
      end
   end

   // read mux; force-reload position always zero
   logic [7:0] readByte;
   always_comb begin
      readByte = PAT_RESET_BYTE;
      if (hitCsr) begin
         readByte = {ctrl.clkSel, ctrl.divSel, ctrl.run, 1'b0, ctrl.ovfIe, overflowFlag};
      end else if (hitCar) begin
         readByte = counter;
      end else if (hitArr) begin
         readByte = reloadValue;
      end else if (hitPwmcr) begin
         readByte = {outEnable, pwmPolarity};
      end else if (hitDutyAny) begin
         readByte = duty[dutySlot];
      end else if (hitCapCsr) begin
         readByte = {2'b00, captureEdgeSelect, captureIrqEnable, captureFlag};
      end else if (hitCapData) begin
         readByte = captureData[capSlot];
      end
   end

   // answer after one access cycle; read data is taken at the setup edge
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         flagSeen <= '0;
      end else begin
         pready <= setupPhase;
         if (setupPhase) begin
            prdata <= {24'h00_0000, readByte};
            pslverr <= ~mapped;
            flagSeen <= captureFlag;
         end
      end
   end

endmodule

/* File: sim/pat_pin_model.sv */
// pat_pin_model: external count clock and capture pins seen by the timer.
// assumes callers enter its tasks just after a rising edge of ref_clk.
`timescale 1ns/1ns
module pat_pin_model
   import pat_pkg::*;
(
   input wire logic ref_clk,
   output logic extClk,
   output logic [PAT_CAP_CH-1:0] captureInputPin
);
   initial begin
      extClk = 1'b0;
      captureInputPin = '0;
   end
   // each level lasts 3 cycles so the two-flop synchroniser never misses it
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         extClk <= 1'b1;
         repeat (3) @(posedge ref_clk);
         extClk <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
   endtask
   task automatic pin_set(input int ch, input logic v);
      @(posedge ref_clk);
      captureInputPin[ch] <= v;
   endtask
endmodule

/* File: sim/pat_timer_checker.sv */
// pat_timer_checker: port-level assertions for the auto-reload PWM timer.
// assumes the pat_timer port list and the register indices of pat_pkg.
`timescale 1ns/1ns
module pat_timer_checker
   import pat_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [PAT_PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [PAT_PWM_CH-1:0] pwmOut,
   input wire logic [PAT_PWM_CH-1:0] pwmOe,
   input wire logic overflowIrq,
   input wire logic captureIrq,
   input wire logic wakeReq
);
   wire done = psel && penable && pready;
   wire wrCsr = done && pwrite && paddr == {PAT_IDX_CSR, 2'b00};
   wire wrPwm = done && pwrite && paddr == {PAT_IDX_PWM_OUTPUT_CONTROL, 2'b00};
   wire wrCap = done && pwrite && paddr == {PAT_IDX_CAPCSR, 2'b00};
   wire rdCsr = done && !pwrite && paddr == {PAT_IDX_CSR, 2'b00};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_read_upper: assert property (done && !pwrite |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
   a_force_reads_zero: assert property (rdCsr |-> !prdata[PAT_CSR_FORCE_RELOAD]) else $error("reload bit read");
   a_ovf_irq_gate: assert property (wrCsr && !pwdata[PAT_CSR_OIE] |-> ##2 !overflowIrq) else $error("ovf irq");
   a_oe_follow: assert property (wrPwm |=> pwmOe == $past(pwdata[7:4])) else $error("enable mismatch");
   a_out_gated: assert property ((pwmOut & ~pwmOe) == 4'h0) else $error("disabled output high");
   a_cap_irq_gate: assert property (wrCap && pwdata[3:2] == 2'h0 |-> ##2 !captureIrq) else $error("cap irq");
   a_wake_pulse: assert property (wakeReq |=> !wakeReq) else $error("wake longer than a cycle");
   a_wake_cause: assert property (wakeReq |-> ##[0:2] captureIrq) else $error("wake without irq");
   a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> pwmOut == 4'h0 && pwmOe == 4'h0
      && !overflowIrq && !captureIrq && !wakeReq) else $error("outputs active after reset");
endmodule

bind pat_timer pat_timer_checker u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pwmOut, .pwmOe, .overflowIrq, .captureIrq, .wakeReq);

/* File: sim/tb_pat_timer.sv */
// tb_pat_timer: self-checking bench for the auto-reload PWM timer over APB.
// assumes pat_timer, pat_pin_model and the bound checker; one 125 MHz clock.
`timescale 1ns/1ns
module tb_pat_timer
   import pat_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [PAT_PADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic halted = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, extClk, overflowIrq, captureIrq, wakeReq;
   logic [PAT_CAP_CH-1:0] captureInputPin;
   logic [PAT_PWM_CH-1:0] pwmOut, pwmOe;
   logic [31:0] seed = 32'hC106772E;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   int wakes = 0;

   pat_timer u_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .extClk, .captureInputPin, .halted, .pwmOut, .pwmOe, .overflowIrq, .captureIrq, .wakeReq);
   pat_pin_model u_pins (.ref_clk, .extClk, .captureInputPin);

   always #4 ref_clk = ~ref_clk;

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [7:0] cnt(input logic [7:0] s, input int k);
      return s + 8'(k);
   endfunction
   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, x);
      end
   endtask
   task automatic chk_pin(input logic [PAT_PWM_CH-1:0] g, input logic [PAT_PWM_CH-1:0] x);
      n_compared++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %0t pin got %h want %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r,
      output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wr(input logic [9:0] i, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, {i, 2'b00}, d, r, e);
   endtask
   task automatic rd(input logic [9:0] i, input logic [7:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, {i, 2'b00}, 8'h00, r, e);
      chk(r, {24'h0, x});
   endtask

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (wakeReq === 1'b1) wakes <= wakes + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         close_out();
      end
   end

   initial begin
      logic [31:0] r;
      logic e;
      logic [7:0] v;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 'h73; i <= 'h7B; i++) rd(i[9:0], 8'h00);
      apb(1'b0, 12'h000, 8'h00, r, e);
      chk({31'h0, e}, 32'h1);
      chk(r, 32'h0);
      for (int n = 3; n < 8; n++) begin
         r = rnd();
         v = {1'b0, r[6:0]};
         wr(PAT_IDX_CSR, {1'b0, n[2:0], 4'h8});
         wr(PAT_IDX_CAR, v);
         repeat ((3 << n) + (1 << (n - 1))) @(posedge ref_clk);
         rd(PAT_IDX_CAR, cnt(v, 3));
      end
      wr(PAT_IDX_CSR, 8'h00);
      wr(PAT_IDX_CAR, v);
      repeat (200) @(posedge ref_clk);
      rd(PAT_IDX_CAR, v);
      wr(PAT_IDX_ARR, 8'h00);
      wr(PAT_IDX_CAR, 8'hFE);
      wr(PAT_IDX_CSR, 8'h0A);
      repeat (4) @(posedge ref_clk);
      chk_pin({3'b000, overflowIrq}, 4'h1);
      rd(PAT_IDX_CSR, 8'h0B);
      rd(PAT_IDX_CSR, 8'h0A);
      r = rnd();
      wr(PAT_IDX_ARR, r[7:0]);
      wr(PAT_IDX_CSR, 8'h05);
      rd(PAT_IDX_CSR, 8'h00);
      rd(PAT_IDX_CAR, r[7:0]);
      wr(PAT_IDX_ARR, 8'hF0);
      wr(PAT_IDX_DUTY0, 8'hF8);
      wr(PAT_IDX_PWM_OUTPUT_CONTROL, 8'h10);
      wr(PAT_IDX_CAR, 8'hFF);
      wr(PAT_IDX_CSR, 8'h78);
      repeat (190) @(posedge ref_clk);
      wr(PAT_IDX_CSR, 8'h00);
      rd(PAT_IDX_CAR, 8'hF0);
      chk_pin(pwmOut, 4'h1);
      wr(PAT_IDX_CAR, 8'hF8);
      chk_pin(pwmOut, 4'h1);
      wr(PAT_IDX_CAR, 8'hF9);
      chk_pin(pwmOut, 4'h0);
      wr(PAT_IDX_DUTY0, 8'hFF);
      chk_pin(pwmOut, 4'h0);
      wr(PAT_IDX_PWM_OUTPUT_CONTROL, 8'hF1);
      chk_pin(pwmOut, 4'h1);
      chk_pin(pwmOe, 4'hF);
      halted <= 1'b1;
      wr(PAT_IDX_CAPCSR, 8'h14);
      u_pins.pin_set(0, 1'b1);
      repeat (8) @(posedge ref_clk);
      chk_pin({3'b000, captureIrq}, 4'h1);
      chk(wakes, 32'h1);
      rd(PAT_IDX_CAPCSR, 8'h15);
      rd(PAT_IDX_CAPDATA1, 8'hF9);
      rd(PAT_IDX_CAPCSR, 8'h14);
      u_pins.pin_set(1, 1'b1);
      u_pins.pin_set(1, 1'b0);
      repeat (8) @(posedge ref_clk);
      chk_pin({3'b000, captureIrq}, 4'h0);
      chk(wakes, 32'h1);
      rd(PAT_IDX_CAPCSR, 8'h16);
      wr(PAT_IDX_CAPCSR, 8'h00);
      halted <= 1'b0;
      wr(PAT_IDX_CAR, 8'h10);
      wr(PAT_IDX_CSR, 8'h88);
      u_pins.ext_pulses(5);
      repeat (6) @(posedge ref_clk);
      wr(PAT_IDX_CSR, 8'h00);
      rd(PAT_IDX_CAR, 8'h15);
      close_out();
   end
endmodule
